// File: design/lbp_led_pwm.sv
// breathing, blinking and general pwm generator for one led output
// assumes a synchronous register port on mclk_in and a free low-speed clock
// assumes software sets commit only after writing the held registers
//
// What this block does
// - asymmetric segment index: top bit falling flag, low bits duty[7:6]
// - segment n picks 4-bit step and interval fields at bits 4n+3:4n
// - blink delay counter ticks from low-speed clock or main clock
// - blink pwm counter advances only when delay counter reaches zero
// - delay counter reloads prescale_load; zero means no prescaling
// - blink mode pwm counter is always 8 bit, counter_size ignored
// - blink period is 256 times prescale_load plus one input ticks
// - blink duty zero keeps led off, maximum duty keeps it on
// - control value 3 forces led continuously on
// - blink output uses only configuration, limits and prescale
// - period ends at wrap from FFh, FEh or FCh by counter size
// - writes may be 32, 16 or 8 bits wide
// - configuration writes act at once
// - limits held, copied to operating limits at every period end
// - delay, step, interval held, copied at period end when commit set
// - hardware clears commit after copying held values
// - symmetry bit one selects asymmetric segments, zero shares all
// - symmetric index is duty top three bits
// - led active while period counter below duty
`timescale 1ns/1ns
`include "lbp_params.svh"

module lbp_led_pwm #(
  parameter int DLY_W = 12
) (
  // clock and synchronous reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // low-speed clock pin, asynchronous to mclk_in
  input wire logic lowclk_in,
  // register port
  input wire lbp_pkg::lbp_req_t req_in,
  output logic [31:0] rdata_out,
  // led drive
  output logic led_out
);
  import lbp_pkg::*;

  // merge write data into a register by byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // pick the 4-bit field of a segment
  function automatic logic [3:0] seg_field(input logic [31:0] v,
                                           input logic [2:0] idx);
    return v[{idx, 2'b00} +: 4];
  endfunction

  logic [31:0] cfg_r;
  logic [31:0] lim_hold_r, lim_op_r;
  logic [31:0] dly_hold_r, dly_op_r;
  logic [31:0] step_hold_r, step_op_r;
  logic [31:0] int_hold_r, int_op_r;
  logic [31:0] odly_r;
  logic [31:0] rdata_r;
  logic led_r;
  logic low_s1_r, low_s2_r, low_s3_r;
  logic [DLY_W-1:0] dly_cnt_r;
  logic [7:0] pwm_cnt_r;
  logic [7:0] duty_r;
  logic [3:0] ivl_cnt_r;
  logic [DLY_W-1:0] hold_cnt_r;
  lbp_phase_t phase_r;

  logic wr_cfg, wr_lim, wr_dly, wr_step, wr_int, wr_odly;
  logic soft_rst;
  logic [1:0] ctl;
  logic [1:0] csize;
  logic blink_mode, breathe_mode;
  logic base_tick, pwm_tick, period_end;
  logic [7:0] cnt_max, cnt_inc;
  logic [2:0] seg_idx;
  logic [3:0] seg_step, seg_ivl;
  logic [DLY_W-1:0] ld_val, hd_val;
  logic [7:0] min_op, max_op;
  logic [8:0] duty_up;
  logic [8:0] duty_floor;

  // address decode
  assign wr_cfg = req_in.wr && (req_in.addr == `LBP_OFS_CFG);
  assign wr_lim = req_in.wr && (req_in.addr == `LBP_OFS_LIM);
  assign wr_dly = req_in.wr && (req_in.addr == `LBP_OFS_DLY);
  assign wr_step = req_in.wr && (req_in.addr == `LBP_OFS_STEP);
  assign wr_int = req_in.wr && (req_in.addr == `LBP_OFS_INT);
  assign wr_odly = req_in.wr && (req_in.addr == `LBP_OFS_ODLY);
  assign soft_rst = wr_cfg && req_in.be[0] &&
                    req_in.wdata[`LBP_SRST_BIT];

  // configuration fields read straight from the live register, delay and limit fields from the operating copies
  assign ctl = cfg_r[`LBP_CTL_LSB +: 2];
  assign csize = cfg_r[`LBP_SIZE_LSB +: 2];
  assign blink_mode = (ctl == `LBP_CTL_BLINK);
  assign breathe_mode = (ctl == `LBP_CTL_BREATHE);
  assign ld_val = dly_op_r[`LBP_LD_LSB +: DLY_W];
  assign hd_val = DLY_W'(dly_op_r[`LBP_HD_LSB +: 8]);
  assign min_op = lim_op_r[`LBP_MIN_LSB +: 8];
  assign max_op = lim_op_r[`LBP_MAX_LSB +: 8];

  // low-speed clock synchroniser; edge seen between stages two and three
  // only stage two reads stage one, so no logic sees a metastable flop
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      low_s1_r <= 1'b0;
      low_s2_r <= 1'b0;
      low_s3_r <= 1'b0;
    end else begin
      low_s1_r <= lowclk_in;
      low_s2_r <= low_s1_r;
      low_s3_r <= low_s2_r;
    end
  end

  // input tick: main clock every cycle, or low-speed rising edge
  assign base_tick = cfg_r[`LBP_CLKSEL_BIT] ? 1'b1
                     : (low_s2_r && !low_s3_r);

  // blink mode is fixed 8 bit; breathing steps 1, 2 or 4 per tick
  always_comb begin
    if (blink_mode) begin
      cnt_max = `LBP_MAX_8;
      cnt_inc = 8'h01;
    end else begin
      case (csize)
        `LBP_SIZE_7: begin
          cnt_max = `LBP_MAX_7;
          cnt_inc = 8'h02;
        end
        `LBP_SIZE_6: begin
          cnt_max = `LBP_MAX_6;
          cnt_inc = 8'h04;
        end
        default: begin
          cnt_max = `LBP_MAX_8;
          cnt_inc = 8'h01;
        end
      endcase
    end
  end

  // pwm counter tick: prescaled in blink mode, direct in breathing
  assign pwm_tick = blink_mode ? (base_tick && dly_cnt_r == '0)
                    : base_tick;
  // at or above the top, so a count left off the step grid by a size
  // change still wraps instead of running on without a period end
  assign period_end = pwm_tick && (pwm_cnt_r >= cnt_max);

  // segment index for step and interval selection
  always_comb begin
    if (cfg_r[`LBP_SYM_BIT]) begin
      seg_idx = {phase_r == BR_FALL, duty_r[7:6]};
    end else begin
      seg_idx = duty_r[7:5];
    end
  end
  assign seg_step = seg_field(step_op_r, seg_idx);
  assign seg_ivl = seg_field(int_op_r, seg_idx);
  assign duty_up = {1'b0, duty_r} + {5'h00, seg_step};
  assign duty_floor = {1'b0, min_op} + {5'h00, seg_step};

  // configuration register; commit flag set by software, cleared on copy
  always_ff @(posedge mclk_in) begin
    if (rst_in || soft_rst) begin
      cfg_r <= `LBP_CFG_RST;
    end else begin
      if (wr_cfg) begin
        cfg_r <= merge(cfg_r, req_in.wdata, req_in.be);
        cfg_r[`LBP_SRST_BIT] <= 1'b0;
        // software can only set commit; a period end with commit pending
        // still clears it unless this same write sets it again
        cfg_r[`LBP_COMMIT_BIT] <=
          (cfg_r[`LBP_COMMIT_BIT] && !period_end) ||
          (req_in.be[0] && req_in.wdata[`LBP_COMMIT_BIT]);
      end else if (period_end && cfg_r[`LBP_COMMIT_BIT]) begin
        cfg_r[`LBP_COMMIT_BIT] <= 1'b0;
      end
    end
  end

  // holding registers, byte lane writes
  always_ff @(posedge mclk_in) begin
    if (rst_in || soft_rst) begin
      lim_hold_r <= `LBP_ZERO_RST;
      dly_hold_r <= `LBP_ZERO_RST;
      step_hold_r <= `LBP_ZERO_RST;
      int_hold_r <= `LBP_ZERO_RST;
      odly_r <= `LBP_ZERO_RST;
    end else begin
      if (wr_lim) begin
        lim_hold_r <= merge(lim_hold_r, req_in.wdata, req_in.be);
      end
      if (wr_dly) begin
        dly_hold_r <= merge(dly_hold_r, req_in.wdata, req_in.be);
      end
      if (wr_step) begin
        step_hold_r <= merge(step_hold_r, req_in.wdata, req_in.be);
      end
      if (wr_int) begin
        int_hold_r <= merge(int_hold_r, req_in.wdata, req_in.be);
      end
      if (wr_odly) begin
        odly_r <= merge(odly_r, req_in.wdata, req_in.be);
      end
    end
  end

  // operating limits copied every period end
  always_ff @(posedge mclk_in) begin
    if (rst_in || soft_rst) begin
      lim_op_r <= `LBP_ZERO_RST;
    end else if (period_end) begin
      lim_op_r <= lim_hold_r;
    end
  end

  // delay, step and interval copied only when commit is pending
  always_ff @(posedge mclk_in) begin
    if (rst_in || soft_rst) begin
      dly_op_r <= `LBP_ZERO_RST;
      step_op_r <= `LBP_ZERO_RST;
      int_op_r <= `LBP_ZERO_RST;
    end else if (period_end && cfg_r[`LBP_COMMIT_BIT]) begin
      dly_op_r <= dly_hold_r;
      step_op_r <= step_hold_r;
      int_op_r <= int_hold_r;
    end
  end

  // delay counter as prescaler in blink mode
  always_ff @(posedge mclk_in) begin
    if (rst_in || soft_rst || !blink_mode) begin
      dly_cnt_r <= '0;
    end else if (base_tick) begin
      if (dly_cnt_r == '0) begin
        dly_cnt_r <= ld_val;
      end else begin
        dly_cnt_r <= dly_cnt_r - DLY_W'(1);
      end
    end
  end

  // pwm period counter
  always_ff @(posedge mclk_in) begin
    if (rst_in || soft_rst || ctl == `LBP_CTL_OFF) begin
      pwm_cnt_r <= 8'h00;
    end else if (pwm_tick) begin
      if (pwm_cnt_r >= cnt_max) begin
        pwm_cnt_r <= 8'h00;
      end else begin
        pwm_cnt_r <= pwm_cnt_r + cnt_inc;
      end
    end
  end

  // breathing ramp engine, advanced once per pwm period
  always_ff @(posedge mclk_in) begin
    if (rst_in || soft_rst || !breathe_mode) begin
      phase_r <= BR_RISE;
      duty_r <= 8'h00;
      ivl_cnt_r <= 4'h0;
      hold_cnt_r <= '0;
    end else if (period_end) begin
      case (phase_r)
        BR_RISE: begin
          if (ivl_cnt_r >= seg_ivl) begin
            ivl_cnt_r <= 4'h0;
            if (duty_up >= {1'b0, max_op}) begin
              duty_r <= max_op;
              hold_cnt_r <= '0;
              phase_r <= BR_HOLD_HI;
            end else begin
              duty_r <= duty_up[7:0];
            end
          end else begin
            ivl_cnt_r <= ivl_cnt_r + 4'h1;
          end
        end
        BR_HOLD_HI: begin
          // hold at the top for hold_count periods
          if (hold_cnt_r >= hd_val) begin
            phase_r <= BR_FALL;
            ivl_cnt_r <= 4'h0;
          end else begin
            hold_cnt_r <= hold_cnt_r + DLY_W'(1);
          end
        end
        BR_FALL: begin
          if (ivl_cnt_r >= seg_ivl) begin
            ivl_cnt_r <= 4'h0;
            if ({1'b0, duty_r} <= duty_floor) begin
              duty_r <= min_op;
              hold_cnt_r <= '0;
              phase_r <= BR_HOLD_LO;
            end else begin
              duty_r <= duty_r - {4'h0, seg_step};
            end
          end else begin
            ivl_cnt_r <= ivl_cnt_r + 4'h1;
          end
        end
        BR_HOLD_LO: begin
          // hold at the floor for prescale_load periods
          if (hold_cnt_r >= ld_val) begin
            phase_r <= BR_RISE;
            ivl_cnt_r <= 4'h0;
          end else begin
            hold_cnt_r <= hold_cnt_r + DLY_W'(1);
          end
        end
        default: begin
          phase_r <= BR_RISE;
        end
      endcase
    end
  end

  // led output from a flop
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      led_r <= 1'b0;
    end else begin
      case (ctl)
        `LBP_CTL_ON: led_r <= 1'b1;
        `LBP_CTL_BLINK: begin
          // only min limit, prescale and config reach here
          led_r <= (min_op == `LBP_FULL_DUTY) ||
                   (pwm_cnt_r < min_op);
        end
        `LBP_CTL_BREATHE: led_r <= (pwm_cnt_r < duty_r);
        // off keeps the led dark
        default: led_r <= 1'b0;
      endcase
    end
  end

  // read data one cycle after the read strobe, zero otherwise
  always_ff @(posedge mclk_in) begin
    if (rst_in || !req_in.rd) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      case (req_in.addr)
        `LBP_OFS_CFG: rdata_r <= cfg_r;
        `LBP_OFS_LIM: rdata_r <= lim_hold_r;
        `LBP_OFS_DLY: rdata_r <= dly_hold_r;
        `LBP_OFS_STEP: rdata_r <= step_hold_r;
        `LBP_OFS_INT: rdata_r <= int_hold_r;
        `LBP_OFS_ODLY: rdata_r <= odly_r;
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // outputs straight from their flops
  assign rdata_out = rdata_r;
  assign led_out = led_r;
endmodule

// File: design/lbp_params.svh
// register offsets, field positions and reset values of the led pwm block
// assumes inclusion by bare name from the design file
`ifndef LBP_PARAMS_SVH
`define LBP_PARAMS_SVH
// register byte offsets
`define LBP_OFS_CFG 8'h00
`define LBP_OFS_LIM 8'h04
`define LBP_OFS_DLY 8'h08
`define LBP_OFS_STEP 8'h0C
`define LBP_OFS_INT 8'h10
`define LBP_OFS_ODLY 8'h14
// configuration fields
`define LBP_CTL_LSB 0
`define LBP_CLKSEL_BIT 2
`define LBP_SIZE_LSB 4
`define LBP_COMMIT_BIT 6
`define LBP_SRST_BIT 7
`define LBP_WDT_LSB 8
`define LBP_SYM_BIT 16
// limit and delay fields
`define LBP_MIN_LSB 0
`define LBP_MAX_LSB 8
`define LBP_LD_LSB 0
`define LBP_HD_LSB 16
// reset values
`define LBP_CFG_RST 32'h0000_1400
`define LBP_ZERO_RST 32'h0000_0000
// control field encodings
`define LBP_CTL_OFF 2'h0
`define LBP_CTL_BREATHE 2'h1
`define LBP_CTL_BLINK 2'h2
`define LBP_CTL_ON 2'h3
// counter size encodings and wrap values
`define LBP_SIZE_7 2'h1
`define LBP_SIZE_6 2'h2
`define LBP_MAX_8 8'hFF
`define LBP_MAX_7 8'hFE
`define LBP_MAX_6 8'hFC
`define LBP_FULL_DUTY 8'hFF
`endif

// File: design/lbp_pkg.sv
// types shared by the led pwm block and its bench
// assumes lbp_params.svh sits beside it
package lbp_pkg;
  // one register request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
    logic rd;
  } lbp_req_t;
  // breathing ramp phase
  typedef enum logic [1:0] {
    BR_RISE,
    BR_HOLD_HI,
    BR_FALL,
    BR_HOLD_LO
  } lbp_phase_t;
endpackage

// File: sim/lbp_led_pwm_checker.sv
// checker for the led pwm block's register port and led drive
// assumes it is bound onto lbp_led_pwm, one clock domain
`timescale 1ns/1ns
module lbp_led_pwm_checker #(
  parameter int DLY_W = 12
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // watched ports
  input wire logic lowclk_in,
  input wire lbp_pkg::lbp_req_t req_in,
  input wire logic [31:0] rdata_out,
  input wire logic led_out
);
  import lbp_pkg::*;
  logic [1:0] ctl_r;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // shadow of the control field as last written
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctl_r <= 2'h0;
    end else if (req_in.wr && req_in.addr == 8'h00 && req_in.be[0]) begin
      ctl_r <= req_in.wdata[7] ? 2'h0 : req_in.wdata[1:0];
    end
  end
  // register port and led relations
  a_idle_read:
    assert property (!req_in.rd |=> rdata_out == 32'h0)
    else $error("read data outside a read");
  a_unmapped_read:
    assert property (req_in.rd && req_in.addr > 8'h14 |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_reset_bit_low:
    assert property (req_in.rd && req_in.addr == 8'h00 |=> !rdata_out[7])
    else $error("soft reset bit reads one");
  a_cfg_readback:
    assert property (req_in.wr && req_in.addr == 8'h00 && req_in.be[0] &&
      !req_in.wdata[7] ##1 req_in.rd && req_in.addr == 8'h00 |=>
      rdata_out[5:0] == $past(req_in.wdata[5:0], 2))
    else $error("config not written at once");
  a_lim_held:
    assert property (req_in.wr && req_in.addr == 8'h04 && req_in.be == 4'hF
      ##1 req_in.rd && req_in.addr == 8'h04 |=>
      rdata_out[15:0] == $past(req_in.wdata[15:0], 2))
    else $error("limit holding value wrong");
  a_dly_held:
    assert property (req_in.wr && req_in.addr == 8'h08 && req_in.be == 4'hF
      ##1 req_in.rd && req_in.addr == 8'h08 |=>
      rdata_out[DLY_W-1:0] == $past(req_in.wdata[DLY_W-1:0], 2))
    else $error("delay holding value wrong");
  a_ramp_held:
    assert property (req_in.wr && req_in.be == 4'hF &&
      (req_in.addr == 8'h0C || req_in.addr == 8'h10) ##1 req_in.rd &&
      req_in.addr == $past(req_in.addr) |=>
      rdata_out == $past(req_in.wdata, 2))
    else $error("ramp holding value wrong");
  a_force_on:
    assert property (ctl_r == 2'h3 |=> led_out)
    else $error("led not forced on");
endmodule

bind lbp_led_pwm lbp_led_pwm_checker #(.DLY_W(DLY_W)) u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .lowclk_in(lowclk_in),
  .req_in(req_in), .rdata_out(rdata_out), .led_out(led_out));

// File: sim/lbp_led_pwm_bench.sv
// self-checking bench for the led pwm block
// assumes design, package and checker are compiled before it
`timescale 1ns/1ns
module lbp_led_pwm_bench;
  import lbp_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic lowclk_in = 1'b0;
  lbp_req_t req_in = '0;
  logic [31:0] rdata_out;
  logic led_out;
  int n_mismatch = 0;
  int checks_done = 0;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  lbp_led_pwm #(.DLY_W(12)) DUT (.mclk_in(mclk_in), .rst_in(rst_in),
    .lowclk_in(lowclk_in), .req_in(req_in), .rdata_out(rdata_out),
    .led_out(led_out));
  // main clock, 4 ns period
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  // low-speed clock, ten main cycles long, moved on main edges
  initial begin
    forever begin
      repeat (5) @(posedge mclk_in);
      lowclk_in <= ~lowclk_in;
    end
  end
  // compare and count
  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one bus cycle, launched just after a rising edge
  task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d,
                     logic [3:0] be);
    @(posedge mclk_in);
    req_in <= '{addr: a, wdata: d, be: be, wr: w, rd: r};
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] be);
    bus(1'b1, 1'b0, a, d, be);
  endtask
  task automatic idle;
    bus(1'b0, 1'b0, 8'h00, 32'h0, 4'h0);
  endtask
  // read, sampled in the one cycle the data stand
  task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] exp);
    bus(1'b0, 1'b1, a, 32'h0, 4'h0);
    idle();
    #1;
    check("read data", exp, rdata_out & m);
  endtask
  // count led high cycles over a window
  task automatic count_hi(int n, int exp);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge mclk_in);
      #1;
      if (led_out === 1'b1) c++;
    end
    check("led high cycles", 32'(exp), 32'(c));
  endtask
  task automatic t_reset_values;
    rd(8'h00, ALL, 32'h0000_1400);
    for (int a = 4; a <= 28; a += 4) rd(8'(a), ALL, 32'h0);
    $display("test reset_values done");
  endtask
  task automatic t_byte_lanes;
    wr(8'h0C, 32'h1122_3344, 4'hF);
    rd(8'h0C, ALL, 32'h1122_3344);
    wr(8'h0C, 32'hAAAA_AAAA, 4'h2);
    wr(8'h0C, 32'h5566_7788, 4'hC);
    rd(8'h0C, ALL, 32'h5566_AA44);
    wr(8'h10, 32'h8765_4321, 4'hF);
    rd(8'h10, ALL, 32'h8765_4321);
    $display("test byte_lanes done");
  endtask
  task automatic t_force_on;
    wr(8'h00, 32'h3, 4'h1);
    rd(8'h00, 32'h3, 32'h3);
    count_hi(300, 300);
    $display("test force_on done");
  endtask
  // blink from main clock, size field set to 7 bit but ignored
  task automatic t_blink;
    logic [7:0] duty [3] = '{8'h00, 8'hFF, 8'h41};
    int hi [3] = '{0, 256, 65};
    wr(8'h00, 32'h16, 4'h1);
    wr(8'h04, 32'h0000_FF10, 4'hF);
    rd(8'h04, 32'hFF, 32'h10);
    foreach (duty[i]) begin
      wr(8'h04, {24'h0, duty[i]}, 4'h1);
      idle();
      repeat (600) @(posedge mclk_in);
      count_hi(256, hi[i]);
    end
    $display("test blink done");
  endtask
  // prescale change held until commit, then copied
  task automatic t_commit;
    wr(8'h08, 32'h1, 4'hF);
    rd(8'h08, 32'hFFF, 32'h1);
    repeat (600) @(posedge mclk_in);
    count_hi(256, 65);
    wr(8'h00, 32'h56, 4'h1);
    rd(8'h00, 32'h7F, 32'h56);
    repeat (600) @(posedge mclk_in);
    rd(8'h00, 32'h40, 32'h0);
    repeat (1100) @(posedge mclk_in);
    count_hi(512, 130);
    $display("test commit done");
  endtask
  // blink from the low-speed clock, prescale one
  task automatic t_low_clock;
    wr(8'h00, 32'h12, 4'h1);
    idle();
    repeat (11000) @(posedge mclk_in);
    count_hi(5120, 1300);
    $display("test low_clock done");
  endtask
  // asymmetric breathing on the main clock, 6-bit size, 64-cycle periods
  task automatic t_breathe;
    wr(8'h00, 32'h0, 4'h1);
    wr(8'h04, 32'h0000_2000, 4'hF);
    wr(8'h08, 32'h0004_0002, 4'hF);
    wr(8'h0C, 32'h000F_000F, 4'hF);
    wr(8'h10, 32'h0, 4'hF);
    wr(8'h00, 32'h0001_0065, 4'h5);
    idle();
    repeat (128) @(posedge mclk_in);
    count_hi(64, 4);
    repeat (128) @(posedge mclk_in);
    count_hi(64, 8);
    repeat (448) @(posedge mclk_in);
    count_hi(64, 0);
    wr(8'h00, 32'h0, 4'h4);
    idle();
    repeat (830) @(posedge mclk_in);
    count_hi(64, 8);
    $display("test breathe done");
  endtask
  // soft reset returns the registers to their reset values
  task automatic t_soft_reset;
    wr(8'h00, 32'h80, 4'h1);
    rd(8'h00, ALL, 32'h0000_1400);
    rd(8'h0C, ALL, 32'h0);
    count_hi(8, 0);
    $display("test soft_reset done");
  endtask
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset_values();
    t_byte_lanes();
    t_force_on();
    t_blink();
    t_commit();
    t_low_clock();
    t_breathe();
    t_soft_reset();
    stop_test();
  end
endmodule
